//--- common/dtsq_pkg.sv
// How it works
// [RULE1] state2 code 0101: channel 3 goes to final, others do nothing
// [RULE2] state2 code 0110: channel 0 to state1, channel 1 to state3
// [RULE3] state2 code 0111: channel 1 to state3, channel 0 to final
// [RULE4] state2 code 1000: channel 0 to state1, channel 2 to state3
// [RULE5] state2 code 1001: channel 2 to state3, channel 0 to final
// [RULE6] state2 code 1010: channel 1 to state1, channel 3 to state3
// [RULE7] state2 code 1011: channel 3 to state3, channel 1 to final
// [RULE8] state2 code 1100: channel 2 to state1, channel 3 to final
// [RULE9] state2 code 1101: channel 2 ignored, channels 0, 1, 3 go to final
// [RULE10] state2 codes 1110 and 1111 never move the sequencer
// [RULE11] simultaneous matches: lowest numbered channel wins
// [RULE12] a match leading to final beats any other simultaneous match
// [RULE13] index 0x27 shows the state3 register only while view select is 10
// [RULE14] state3 register writes need view select 10 and a disarmed module
// [RULE15] state3 register: select in bits 3..0, upper bits read zero, resets zero
// [RULE16] state3 code 0000 any match to state1, code 0001 any match to state2
// [RULE17] software enables a comparator before its matches count
// [RULE18] view select maps comparator a, b or c into window 0x28..0x2f
// [RULE19] view select 11 shows comparator d control plus three address registers
// [RULE20] state register changes only on a qualifying match while armed, once per cycle, or on arming, which restarts it in state1
// [RULE21] state3 codes other than 0000 and 0001 cause no transition
package dtsq_pkg;

    typedef enum logic [1:0] {SEQ_S1, SEQ_S2, SEQ_S3, SEQ_FINAL} dtsq_state_e;

    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned WIN_BYTES     = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL      = 8'h20;
    localparam logic [7:0]  IDX_SEQ       = 8'h27;
    localparam logic [7:0]  IDX_WIN_LO    = 8'h28;
    localparam logic [7:0]  IDX_WIN_HI    = 8'h2F;
    localparam int unsigned CTRL_ARM_BIT  = 7;
    localparam int unsigned COMP_EN_BIT   = 0;
    localparam logic [1:0]  VIEW_A        = 2'h0;
    localparam logic [1:0]  VIEW_B        = 2'h1;
    localparam logic [1:0]  VIEW_C        = 2'h2;
    localparam logic [1:0]  VIEW_D        = 2'h3;
    localparam logic [3:0]  WIN_LEN_FULL  = 4'h8;
    localparam logic [3:0]  WIN_LEN_SHORT = 4'h4;
    localparam logic [3:0]  SC_RESET      = 4'h0;
    localparam logic [1:0]  VIEW_RESET    = 2'h0;
    localparam logic [7:0]  BANK_RESET    = 8'h00;

    localparam logic [3:0]  SC2_M3F       = 4'h5;
    localparam logic [3:0]  SC2_M0S1_M1S3 = 4'h6;
    localparam logic [3:0]  SC2_M1S3_M0F  = 4'h7;
    localparam logic [3:0]  SC2_M0S1_M2S3 = 4'h8;
    localparam logic [3:0]  SC2_M2S3_M0F  = 4'h9;
    localparam logic [3:0]  SC2_M1S1_M3S3 = 4'hA;
    localparam logic [3:0]  SC2_M3S3_M1F  = 4'hB;
    localparam logic [3:0]  SC2_M2S1_M3F  = 4'hC;
    localparam logic [3:0]  SC2_NOT2_F    = 4'hD;
    localparam logic [3:0]  SC3_TO_S1     = 4'h0;
    localparam logic [3:0]  SC3_TO_S2     = 4'h1;

endpackage

//--- design/dtsq_next.sv
`timescale 1ns/10ps
module dtsq_next (
    input  dtsq_pkg::dtsq_state_e state_i,
    input  logic [3:0]            match_i,
    input  logic [3:0]            sc2_i,
    input  logic [3:0]            sc3_i,
    output logic                  move_o,
    output dtsq_pkg::dtsq_state_e next_o
);
    // per channel: {valid, destination}
    localparam logic [2:0] G_NO = 3'h0;
    localparam logic [2:0] G_S1 = {1'b1, dtsq_pkg::SEQ_S1};
    localparam logic [2:0] G_S2 = {1'b1, dtsq_pkg::SEQ_S2};
    localparam logic [2:0] G_S3 = {1'b1, dtsq_pkg::SEQ_S3};
    localparam logic [2:0] G_F  = {1'b1, dtsq_pkg::SEQ_FINAL};

    logic [11:0] tbl;
    logic [3:0]  hit;
    logic [3:0]  fin;

    always_comb begin
        tbl = {4{G_NO}};
        case (state_i)
            dtsq_pkg::SEQ_S1: tbl = {4{G_S2}};
            dtsq_pkg::SEQ_S2: begin
                case (sc2_i)
                    dtsq_pkg::SC2_M3F:       tbl = {G_F, G_NO, G_NO, G_NO}; // RULE1
                    dtsq_pkg::SC2_M0S1_M1S3: tbl = {G_NO, G_NO, G_S3, G_S1}; // RULE2
                    dtsq_pkg::SC2_M1S3_M0F:  tbl = {G_NO, G_NO, G_S3, G_F}; // RULE3
                    dtsq_pkg::SC2_M0S1_M2S3: tbl = {G_NO, G_S3, G_NO, G_S1}; // RULE4
                    dtsq_pkg::SC2_M2S3_M0F:  tbl = {G_NO, G_S3, G_NO, G_F}; // RULE5
                    dtsq_pkg::SC2_M1S1_M3S3: tbl = {G_S3, G_NO, G_S1, G_NO}; // RULE6
                    dtsq_pkg::SC2_M3S3_M1F:  tbl = {G_S3, G_NO, G_F, G_NO}; // RULE7
                    dtsq_pkg::SC2_M2S1_M3F:  tbl = {G_F, G_S1, G_NO, G_NO}; // RULE8
                    dtsq_pkg::SC2_NOT2_F:    tbl = {G_F, G_NO, G_F, G_F}; // RULE9
                    default:                 tbl = {4{G_NO}}; // RULE10
                endcase
            end
            dtsq_pkg::SEQ_S3: begin
                case (sc3_i)
                    dtsq_pkg::SC3_TO_S1: tbl = {4{G_S1}}; // RULE16
                    dtsq_pkg::SC3_TO_S2: tbl = {4{G_S2}}; // RULE16
                    default:             tbl = {4{G_NO}}; // RULE21
                endcase
            end
            default: tbl = {4{G_NO}};
        endcase
    end

    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_ch
            assign hit[c] = match_i[c] & tbl[3*c+2];
            assign fin[c] = hit[c] & (tbl[3*c +: 2] == dtsq_pkg::SEQ_FINAL);
        end
    endgenerate

    always_comb begin
        move_o = |hit;
        next_o = state_i;
        for (int i = 3; i >= 0; i--) begin
            if (hit[i]) begin
                next_o = dtsq_pkg::dtsq_state_e'(tbl[3*i +: 2]); // RULE11
            end
        end
        if (|fin) begin
            next_o = dtsq_pkg::SEQ_FINAL; // RULE12
        end
    end

endmodule

//--- design/dtsq_top.sv
`timescale 1ns/10ps
module dtsq_top #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              CLK_I,
    input  wire logic              NRST_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic [3:0]        MATCH_I,
    output logic      [1:0]        SEQ_STATE_O,
    output logic                   ARMED_O,
    output logic                   FINAL_O
);

    generate
        if (ADDR_W < 10) begin : g_chk
            $error("ADDR_W must be at least 10");
        end
    endgenerate

    typedef struct packed {
        logic                       armed;
        logic                       final_hit;
        logic [1:0]                 view;
        logic [3:0]                 sc2;
        logic [3:0]                 sc3;
        dtsq_pkg::dtsq_state_e      seq;
        logic [3:0][7:0][7:0]       bank;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
    } dtsq_main_s;

    // all-zero reset: sequencer in state1, disarmed, view a, selects zero
    localparam dtsq_main_s RST_STATE = '0;

    dtsq_main_s            cur_r;
    dtsq_main_s            cur_nxt;
    logic [7:0]            idx;
    logic                  addr_ok;
    logic [2:0]            win_off;
    logic [3:0]            win_len;
    logic                  rd_hit;
    logic [7:0]            rd_data;
    logic                  setup;
    logic                  acc_wr;
    logic                  ctrl_wr;
    logic                  arm_new;
    logic [3:0]            gm;
    logic                  seq_move;
    dtsq_pkg::dtsq_state_e seq_next;

    assign idx     = PADDR_I[9:2];
    assign addr_ok = (PADDR_I[1:0] == 2'b00) && ((PADDR_I >> 10) == '0);
    assign win_off = idx[2:0];
    assign setup   = PSEL_I & ~PENABLE_I;
    // write lands on the access edge at which pready is seen high
    assign acc_wr  = PSEL_I & PENABLE_I & cur_r.pready & PWRITE_I & rd_hit;
    assign ctrl_wr = acc_wr && (idx == dtsq_pkg::IDX_CTRL);
    assign arm_new = PWDATA_I[dtsq_pkg::CTRL_ARM_BIT];

    // a comparator left disabled never reaches the sequencer
    genvar c;
    generate
        for (c = 0; c < dtsq_pkg::NUM_CH; c++) begin : g_gate
            assign gm[c] = MATCH_I[c] & cur_r.bank[c][0][dtsq_pkg::COMP_EN_BIT]; // RULE17
        end
    endgenerate

    dtsq_next u_next (
        .state_i (cur_r.seq),
        .match_i (gm),
        .sc2_i   (cur_r.sc2),
        .sc3_i   (cur_r.sc3),
        .move_o  (seq_move),
        .next_o  (seq_next)
    );

    // comparators b and d only back the first four window bytes
    always_comb begin
        win_len = dtsq_pkg::WIN_LEN_FULL; // RULE18
        if (cur_r.view == dtsq_pkg::VIEW_B || cur_r.view == dtsq_pkg::VIEW_D) begin
            win_len = dtsq_pkg::WIN_LEN_SHORT; // RULE19
        end
    end

    always_comb begin
        rd_hit  = 1'b0;
        rd_data = 8'h00;
        if (addr_ok) begin
            if (idx == dtsq_pkg::IDX_CTRL) begin
                rd_hit  = 1'b1;
                rd_data = {cur_r.armed, 5'h00, cur_r.view};
            end else if (idx == dtsq_pkg::IDX_SEQ) begin
                rd_hit = 1'b1;
                case (cur_r.view)
                    dtsq_pkg::VIEW_A: rd_data = {cur_r.armed, cur_r.final_hit, 4'h0, cur_r.seq};
                    dtsq_pkg::VIEW_B: rd_data = {4'h0, cur_r.sc2};
                    dtsq_pkg::VIEW_C: rd_data = {4'h0, cur_r.sc3}; // RULE13 RULE15
                    default:          rd_data = {4'h0, gm};
                endcase
            end else if (idx >= dtsq_pkg::IDX_WIN_LO && idx <= dtsq_pkg::IDX_WIN_HI) begin
                rd_hit = 1'b1;
                if ({1'b0, win_off} < win_len) begin
                    rd_data = cur_r.bank[cur_r.view][win_off]; // RULE18 RULE19
                end
            end
        end
    end

    always_comb begin
        cur_nxt        = cur_r;
        cur_nxt.pready = 1'b0;
        if (setup) begin
            // answer is prepared in setup so the access phase needs no wait
            cur_nxt.pready  = 1'b1;
            cur_nxt.prdata  = {24'h00_0000, rd_data};
            cur_nxt.pslverr = ~rd_hit;
        end
        if (cur_r.armed && seq_move) begin
            cur_nxt.seq = seq_next; // RULE20
            if (seq_next == dtsq_pkg::SEQ_FINAL) begin
                cur_nxt.armed     = 1'b0;
                cur_nxt.final_hit = 1'b1;
            end
        end
        // software writes come last so their armed and view values win over a same-cycle move; the state still takes the move
        if (ctrl_wr) begin
            cur_nxt.view  = PWDATA_I[1:0];
            cur_nxt.armed = arm_new;
            if (arm_new && !cur_r.armed) begin
                cur_nxt.seq       = dtsq_pkg::SEQ_S1;
                cur_nxt.final_hit = 1'b0;
            end
        end else if (acc_wr && !cur_r.armed) begin
            if (idx == dtsq_pkg::IDX_SEQ) begin
                if (cur_r.view == dtsq_pkg::VIEW_B) begin
                    cur_nxt.sc2 = PWDATA_I[3:0];
                end else if (cur_r.view == dtsq_pkg::VIEW_C) begin
                    cur_nxt.sc3 = PWDATA_I[3:0]; // RULE14
                end
            end else if ({1'b0, win_off} < win_len) begin
                cur_nxt.bank[cur_r.view][win_off] = PWDATA_I[7:0];
            end
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cur_r <= RST_STATE; // RULE15
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign PRDATA_O    = cur_r.prdata;
    assign PREADY_O    = cur_r.pready;
    assign PSLVERR_O   = cur_r.pslverr;
    assign SEQ_STATE_O = cur_r.seq;
    assign ARMED_O     = cur_r.armed;
    assign FINAL_O     = cur_r.final_hit;

    // checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    logic live;
    logic sc3_try;
    logic in_s2;
    logic in_s3;
    assign live    = cur_r.armed && !ctrl_wr;
    assign sc3_try = PSEL_I && PENABLE_I && cur_r.pready && PWRITE_I && addr_ok
                     && idx == dtsq_pkg::IDX_SEQ && cur_r.view == dtsq_pkg::VIEW_C && cur_r.armed;
    assign in_s2   = live && cur_r.seq == dtsq_pkg::SEQ_S2;
    assign in_s3   = live && cur_r.seq == dtsq_pkg::SEQ_S3;

    a_s2_ch3_final: // RULE1
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'h5 && gm[3]
                     |=> cur_r.seq == dtsq_pkg::SEQ_FINAL && !cur_r.armed && FINAL_O)
    else $error("code 0101 channel 3 did not reach final");

    a_s2_ch0_state1: // RULE2
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'h6 && gm[0]
                     |=> cur_r.seq == dtsq_pkg::SEQ_S1)
    else $error("code 0110 channel 0 did not reach state1");

    a_s2_ch0_final: // RULE3
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'h7 && gm[0]
                     |=> cur_r.seq == dtsq_pkg::SEQ_FINAL)
    else $error("code 0111 channel 0 did not reach final");

    a_s2_ch2_state3: // RULE4
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'h8 && gm == 4'h4
                     |=> cur_r.seq == dtsq_pkg::SEQ_S3)
    else $error("code 1000 channel 2 did not reach state3");

    a_final_wins: // RULE12
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'hC && gm[2] && gm[3]
                     |=> cur_r.seq == dtsq_pkg::SEQ_FINAL)
    else $error("final target lost to a lower channel");

    a_low_channel_wins: // RULE11
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'hA && gm[1] && gm[3]
                     |=> cur_r.seq == dtsq_pkg::SEQ_S1)
    else $error("higher channel overrode a lower one");

    a_s2_ch2_ignored: // RULE9
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2 == 4'hD && gm == 4'h4
                     |=> $stable(cur_r.seq) ##1 1'b1)
    else $error("code 1101 channel 2 moved the sequencer");

    a_reserved_hold: // RULE10
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S2 && cur_r.sc2[3:1] == 3'b111
                     |=> cur_r.seq == dtsq_pkg::SEQ_S2)
    else $error("reserved state2 code moved the sequencer");

    a_s3_any_state2: // RULE16
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S3 && cur_r.sc3 == 4'h1 && |gm
                     |=> cur_r.seq == dtsq_pkg::SEQ_S2)
    else $error("state3 code 0001 did not reach state2");

    a_s3_armed_lock: // RULE14
    assert property (sc3_try |=> $stable(cur_r.sc3) [*2])
    else $error("state3 select changed while armed");

    a_s3_read_view: // RULE13
    assert property (setup && !PWRITE_I && addr_ok && idx == dtsq_pkg::IDX_SEQ
                     && cur_r.view == dtsq_pkg::VIEW_C
                     |=> PREADY_O && !PSLVERR_O && PRDATA_O == {28'h000_0000, $past(cur_r.sc3)})
    else $error("state3 register read wrong");

    a_idle_frozen: // RULE20
    assert property (!cur_r.armed && !ctrl_wr |=> $stable(cur_r.seq))
    else $error("sequencer moved while disarmed");

    a_code9_state3: // RULE5
    assert property (in_s2 && cur_r.sc2 == 4'h9 && gm == 4'h4
                     |=> cur_r.seq == dtsq_pkg::SEQ_S3)
    else $error("code 1001 channel 2 did not reach state3");

    a_code9_final: // RULE5
    assert property (in_s2 && cur_r.sc2 == 4'h9 && gm[0]
                     |=> cur_r.seq == dtsq_pkg::SEQ_FINAL)
    else $error("code 1001 channel 0 did not reach final");

    a_code10_state3: // RULE6
    assert property (in_s2 && cur_r.sc2 == 4'hA && gm == 4'h8
                     |=> cur_r.seq == dtsq_pkg::SEQ_S3)
    else $error("code 1010 channel 3 did not reach state3");

    a_code11_final: // RULE7
    assert property (in_s2 && cur_r.sc2 == 4'hB && gm[1]
                     |=> cur_r.seq == dtsq_pkg::SEQ_FINAL)
    else $error("code 1011 channel 1 did not reach final");

    a_code11_state3: // RULE7
    assert property (in_s2 && cur_r.sc2 == 4'hB && gm == 4'h8
                     |=> cur_r.seq == dtsq_pkg::SEQ_S3)
    else $error("code 1011 channel 3 did not reach state3");

    a_code12_state1: // RULE8
    assert property (in_s2 && cur_r.sc2 == 4'hC && gm == 4'h4
                     |=> cur_r.seq == dtsq_pkg::SEQ_S1)
    else $error("code 1100 channel 2 did not reach state1");

    a_code13_final: // RULE9
    assert property (in_s2 && cur_r.sc2 == 4'hD && (gm & 4'hB) != 4'h0
                     |=> cur_r.seq == dtsq_pkg::SEQ_FINAL)
    else $error("code 1101 channel 0, 1 or 3 did not reach final");

    a_code5_ignore: // RULE1
    assert property (in_s2 && cur_r.sc2 == 4'h5 && !gm[3]
                     |=> cur_r.seq == dtsq_pkg::SEQ_S2)
    else $error("code 0101 moved on a channel other than 3");

    a_s3_any_state1: // RULE16
    assert property (in_s3 && cur_r.sc3 == 4'h0 && |gm
                     |=> cur_r.seq == dtsq_pkg::SEQ_S1)
    else $error("state3 code 0000 did not reach state1");

    a_s3_other_hold: // RULE21
    assert property (in_s3 && cur_r.sc3 > 4'h1
                     |=> cur_r.seq == dtsq_pkg::SEQ_S3)
    else $error("undefined state3 code moved the sequencer");

    a_s1_any_state2: // RULE20
    assert property (live && cur_r.seq == dtsq_pkg::SEQ_S1 && |gm
                     |=> cur_r.seq == dtsq_pkg::SEQ_S2)
    else $error("state1 match did not reach state2");

    a_armed_only_move: // RULE20
    assert property (!ctrl_wr && !(cur_r.armed && |gm)
                     |=> $stable(cur_r.seq))
    else $error("sequencer moved without a qualifying match");

    a_ready_once: // RULE13
    assert property (setup
                     |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not a single cycle after setup");

    a_short_window: // RULE19
    assert property (setup && !PWRITE_I && addr_ok && idx >= dtsq_pkg::IDX_WIN_LO && idx[2] && cur_r.view[0]
                     |=> PRDATA_O == 32'h0000_0000)
    else $error("upper window byte of a short bank read nonzero");

    a_view_lock: // RULE14
    assert property (PSEL_I && PENABLE_I && PWRITE_I && idx == dtsq_pkg::IDX_SEQ && cur_r.view != dtsq_pkg::VIEW_C
                     |=> $stable(cur_r.sc3))
    else $error("state3 select written outside its view");

    a_arm_restart: // RULE20
    assert property (ctrl_wr && arm_new && !cur_r.armed
                     |=> SEQ_STATE_O == dtsq_pkg::SEQ_S1 && ARMED_O && !FINAL_O)
    else $error("arming did not restart in state1");

    a_final_sticky: // RULE20
    assert property (FINAL_O && !ctrl_wr
                     |=> FINAL_O && cur_r.seq == dtsq_pkg::SEQ_FINAL)
    else $error("final state left without a control write");

    c_reach_final:
    cover property (cur_r.seq == dtsq_pkg::SEQ_S3 ##[1:50] cur_r.seq == dtsq_pkg::SEQ_FINAL);

    c_s2_to_s3:
    cover property (cur_r.seq == dtsq_pkg::SEQ_S2 ##1 cur_r.seq == dtsq_pkg::SEQ_S3);

    c_view_d_write:
    cover property (acc_wr && cur_r.view == dtsq_pkg::VIEW_D && idx >= dtsq_pkg::IDX_WIN_LO);

    c_s3_to_s1:
    cover property (cur_r.seq == dtsq_pkg::SEQ_S3 ##1 cur_r.seq == dtsq_pkg::SEQ_S1);

    c_arm_restart:
    cover property (ctrl_wr && arm_new && !cur_r.armed);

endmodule

//--- tb/dtsq_match_src.sv
`timescale 1ns/10ps
module dtsq_match_src (
    input  wire logic [3:0] req_i,
    input  wire logic [3:0] enable_i,
    output logic      [3:0] match_o
);
    // a comparator that software left disabled never reports a match
    assign match_o = req_i & enable_i;
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module tb;
    logic        clk       = 1'b0;
    logic        nrst      = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [3:0]  req       = 4'h0;
    logic [3:0]  comp_en   = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  match;
    logic [1:0]  seq_state;
    logic        armed;
    logic        final_hit;
    logic [31:0] rd;
    logic        err;
    logic [15:0] tab [16];
    int          miscompares     = 0;
    int          samples_checked = 0;
    int          st              = 0;
    int          sc2             = 0;
    int          sc3             = 0;

    always #20 clk = ~clk;

    dtsq_top #(.ADDR_W(12)) u_dtsq_top (
        .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .MATCH_I(match), .SEQ_STATE_O(seq_state), .ARMED_O(armed),
        .FINAL_O(final_hit)
    );

    dtsq_match_src u_dtsq_match_src (.req_i(req), .enable_i(comp_en), .match_o(match));

    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        // no limit here: a hung transfer is ended by the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // lowest matching channel picks the target, but any match aiming at final wins
    function automatic int mdl(int s, int m);
        int nx;
        nx = s;
        if (m == 0 || s == 3)
            return s;
        if (s == 0)
            return 1;
        if (s == 2)
            return (sc3 == 0) ? 0 : (sc3 == 1) ? 1 : 2;
        for (int i = 3; i >= 0; i--)
            if (m[i] && tab[sc2][4*i +: 4] != 4'hF) nx = tab[sc2][4*i +: 4];
        for (int i = 0; i < 4; i++)
            if (m[i] && tab[sc2][4*i +: 4] == 4'h3) nx = 3;
        return nx;
    endfunction

    task automatic pulse(input int m);
        @(posedge clk);
        req <= m[3:0];
        @(posedge clk);
        req <= 4'h0;
        #1;
        st = mdl(st, m);
        `CHK("state", st, seq_state)
        `CHK("armed", (st != 3), armed)
        `CHK("final", (st == 3), final_hit)
    endtask

    task automatic to_state2(input int c);
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_B});
        apb(1'b1, dtsq_pkg::IDX_SEQ, c[7:0]);
        sc2 = c;
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h20, dtsq_pkg::VIEW_B});
        st = 0;
        pulse($urandom_range(1, 15));
    endtask

    initial begin
        void'($urandom(57));
        tab = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h3FFF, 16'hFF20, 16'hFF23,
                16'hF2F0, 16'hF2F3, 16'h2F0F, 16'h2F3F, 16'h30FF, 16'h3F33, 16'hFFFF, 16'hFFFF};
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, dtsq_pkg::IDX_SEQ, 8'h00);
        `CHK("status", 32'h0000_0000, rd)
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_C});
        apb(1'b0, dtsq_pkg::IDX_SEQ, 8'h00);
        `CHK("select reset", 32'h0000_0000, rd)
        apb(1'b1, dtsq_pkg::IDX_SEQ, 8'hFF);
        apb(1'b0, dtsq_pkg::IDX_SEQ, 8'h00);
        `CHK("select bits", 32'h0000_000F, rd)
        `CHK("mapped error", 1'b0, err)
        apb(1'b0, 8'h10, 8'h00);
        `CHK("unmapped error", 1'b1, err)
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, dtsq_pkg::IDX_CTRL, v[7:0]);
            apb(1'b1, dtsq_pkg::IDX_WIN_LO, 8'h01);
            apb(1'b0, dtsq_pkg::IDX_WIN_LO, 8'h00);
            `CHK("bank control", 32'h0000_0001, rd)
            apb(1'b1, dtsq_pkg::IDX_WIN_HI, 8'h5A);
            apb(1'b0, dtsq_pkg::IDX_WIN_HI, 8'h00);
            `CHK("bank upper", (v % 2 == 1) ? 32'h0000_0000 : 32'h0000_005A, rd)
        end
        comp_en <= 4'hF;
        for (int c = 0; c < 16; c++)
            for (int m = 0; m < 16; m++) begin
                to_state2(c);
                pulse(m);
            end
        for (int c = 0; c < 16; c++)
            for (int m = 0; m < 16; m++) begin
                apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_C});
                apb(1'b1, dtsq_pkg::IDX_SEQ, c[7:0]);
                sc3 = c;
                to_state2(6);
                pulse(2);
                pulse(m);
            end
        // armed writes and writes in the wrong view must leave the select untouched
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h20, dtsq_pkg::VIEW_C});
        apb(1'b1, dtsq_pkg::IDX_SEQ, 8'h05);
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_C});
        apb(1'b0, dtsq_pkg::IDX_SEQ, 8'h00);
        `CHK("armed write", sc3, rd)
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_A});
        apb(1'b1, dtsq_pkg::IDX_SEQ, 8'h09);
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_C});
        apb(1'b0, dtsq_pkg::IDX_SEQ, 8'h00);
        `CHK("view write", sc3, rd)
        to_state2(5);
        @(posedge clk);
        nrst <= 1'b0;
        req  <= 4'hF;
        @(posedge clk);
        #1;
        `CHK("reset state", 2'b00, seq_state)
        `CHK("reset armed", 1'b0, armed)
        `CHK("reset final", 1'b0, final_hit)
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        req  <= 4'h0;
        #1;
        `CHK("idle after reset", 2'b00, seq_state)
        `CHK("ready after reset", 1'b0, pready)
        apb(1'b1, dtsq_pkg::IDX_CTRL, {6'h00, dtsq_pkg::VIEW_C});
        apb(1'b0, dtsq_pkg::IDX_SEQ, 8'h00);
        `CHK("select after reset", 32'h0000_0000, rd)
        complete_run();
    end

    initial begin
        #(40 * 40000);
        miscompares++;
        complete_run();
    end
endmodule
